// file: dpa_alu.sv
// Summary of operation
// - execute only when condition code passes
// - first operand always from selected register
// - operand two: shifted register or rotated immediate
// - flags change only with set-flags bit or a software write
// - test operations set flags, never write
// - logical opcodes: and, xor, or, bit clear
// - subtract, reverse subtract, add, add carry
// - subtracts with carry minus one
// - opcodes eight to eleven only set flags
// - move and move inverted ignore operand one
// - logical flag update keeps overflow
// - logical carry from shifter, shift zero keeps
// - logical zero and negative from result
// - arithmetic overflow on signed overflow
// - arithmetic carry, zero, negative from adder
// - no flag update for program counter destination
// - immediate rotated right by twice rotate field
`timescale 1ns/100ps
`include "dpa_regs.svh"
module dpa_alu #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_b_i,
    // instruction issue
    input  wire logic                issue_valid_i,
    output logic                     issue_ready_o,
    input  wire logic [31:0]         instr_i,
    // register file read
    output logic      [3:0]          rn_idx_o,
    output logic      [3:0]          rm_idx_o,
    output logic      [3:0]          rs_idx_o,
    input  wire logic [31:0]         rn_val_i,
    input  wire logic [31:0]         rm_val_i,
    input  wire logic [31:0]         rs_val_i,
    // register file write and status
    output dpa_pkg::dpa_wr_t         wr_o,
    output dpa_pkg::dpa_flags_t      flags_o,
    output logic                     done_o,
    output logic                     pc_restore_o,
    // wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    dpa_pkg::dpa_state_t  state_r;
    logic [31:0]          instr_r;
    dpa_pkg::dpa_flags_t  flags_r;
    dpa_pkg::dpa_flags_t  flags_nxt;
    dpa_pkg::dpa_wr_t     wr_r;
    logic [31:0]          res_r;
    logic [CNT_W-1:0]     count_r;
    logic                 done_r;
    logic                 pc_restore_r;
    logic                 skipped_r;
    logic                 wrote_r;
    logic                 ack_r;
    logic [31:0]          dat_r;

    // ****************************************************************
    // decode
    // ****************************************************************
    logic [3:0]           cond;
    logic                 imm_sel;
    dpa_pkg::dpa_opcode_t opc;
    logic                 set_f;
    logic [3:0]           rd;
    logic [11:0]          spec;
    logic                 exec;
    logic                 cond_ok;
    logic [31:0]          op1;
    logic [31:0]          op2;
    logic                 sh_carry;
    logic [31:0]          add_a;
    logic [31:0]          add_b;
    logic                 add_cin;
    logic [32:0]          sum;
    logic [31:0]          res;
    logic                 is_arith;
    logic                 ovf;
    logic                 test_op;
    logic                 flag_upd;
    logic                 do_write;
    logic                 wb_req;
    logic                 sw_flag_we;

    assign cond    = instr_r[`DPA_COND_HI:`DPA_COND_LO];
    assign imm_sel = instr_r[`DPA_IMM_BIT];
    assign opc     = dpa_pkg::dpa_opcode_t'(instr_r[`DPA_OPC_HI:`DPA_OPC_LO]);
    assign set_f   = instr_r[`DPA_SET_BIT];
    assign rd      = instr_r[`DPA_RD_HI:`DPA_RD_LO];
    assign spec    = instr_r[`DPA_SPEC_HI:`DPA_SPEC_LO];
    assign exec    = state_r == dpa_pkg::DPA_ST_EXEC;

    // register file reads asynchronously in the execute cycle
    assign rn_idx_o = instr_r[`DPA_RN_HI:`DPA_RN_LO];
    assign rm_idx_o = instr_r[`DPA_RM_HI:`DPA_RM_LO];
    assign rs_idx_o = instr_r[`DPA_RS_HI:`DPA_RS_LO];
    assign op1      = rn_val_i;

    assign issue_ready_o = state_r == dpa_pkg::DPA_ST_IDLE;

    dpa_cond_eval u_cond (
        .cond_i  (cond),
        .flags_i (flags_r),
        .pass_o  (cond_ok)
    );

    dpa_shifter u_shift (
        .imm_sel_i (imm_sel),
        .spec_i    (spec),
        .rm_val_i  (rm_val_i),
        .rs_val_i  (rs_val_i),
        .carry_i   (flags_r.c),
        .op2_o     (op2),
        .carry_o   (sh_carry)
    );

    // ****************************************************************
    // operation
    // ****************************************************************
    always_comb begin
        add_a    = op1;
        add_b    = op2;
        add_cin  = 1'b0;
        res      = 32'h0;
        is_arith = 1'b0;
        unique case (opc)
            dpa_pkg::DPA_OP_AND, dpa_pkg::DPA_OP_TEST_BITS:        res = op1 & op2;
            dpa_pkg::DPA_OP_EXCLUSIVE_OR,
            dpa_pkg::DPA_OP_TEST_EQUIVALENCE:                      res = op1 ^ op2;
            dpa_pkg::DPA_OP_INCLUSIVE_OR:                          res = op1 | op2;
            dpa_pkg::DPA_OP_BIT_CLEAR:                             res = op1 & ~op2;
            dpa_pkg::DPA_OP_MOVE:                                  res = op2;
            dpa_pkg::DPA_OP_MOVE_INVERTED:                         res = ~op2;
            dpa_pkg::DPA_OP_SUBTRACT, dpa_pkg::DPA_OP_COMPARE: begin
                is_arith = 1'b1;
                add_b    = ~op2;
                add_cin  = 1'b1;
            end
            dpa_pkg::DPA_OP_REVERSE_SUBTRACT: begin
                is_arith = 1'b1;
                add_a    = op2;
                add_b    = ~op1;
                add_cin  = 1'b1;
            end
            dpa_pkg::DPA_OP_ADD, dpa_pkg::DPA_OP_COMPARE_NEGATED:  is_arith = 1'b1;
            dpa_pkg::DPA_OP_ADD_CARRY: begin
                is_arith = 1'b1;
                add_cin  = flags_r.c;
            end
            dpa_pkg::DPA_OP_SUBTRACT_CARRY: begin
                is_arith = 1'b1;
                add_b    = ~op2;
                add_cin  = flags_r.c;
            end
            dpa_pkg::DPA_OP_REVERSE_SUBTRACT_CARRY: begin
                is_arith = 1'b1;
                add_a    = op2;
                add_b    = ~op1;
                add_cin  = flags_r.c;
            end
        endcase
        // one 33-bit adder; inverted inputs give subtraction
        sum = {1'b0, add_a} + {1'b0, add_b} + {32'h0, add_cin};
        if (is_arith) begin
            res = sum[31:0];
        end
    end

    assign ovf      = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
    assign test_op  = opc[3:2] == 2'b10;
    // a pc destination hands its flags to the mode logic outside
    assign flag_upd = exec && cond_ok && set_f && rd != `DPA_PC_IDX;
    assign do_write = exec && cond_ok && !test_op;

    always_comb begin
        flags_nxt   = flags_r;
        flags_nxt.n = res[31];
        flags_nxt.z = res == 32'h0;
        flags_nxt.c = is_arith ? sum[32] : sh_carry;
        flags_nxt.v = is_arith ? ovf : flags_r.v;
    end

    // ****************************************************************
    // sequencing
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            state_r <= dpa_pkg::DPA_ST_IDLE;
            instr_r <= 32'h0;
        end else begin
            unique case (state_r)
                dpa_pkg::DPA_ST_IDLE: begin
                    if (issue_valid_i) begin
                        state_r <= dpa_pkg::DPA_ST_EXEC;
                        instr_r <= instr_i;
                    end
                end
                dpa_pkg::DPA_ST_EXEC: state_r <= dpa_pkg::DPA_ST_IDLE;
            endcase
        end
    end

    // hardware update wins over a software write in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            flags_r <= `DPA_FLAGS_RST;
        end else if (flag_upd) begin
            flags_r <= flags_nxt;
        end else if (sw_flag_we) begin
            flags_r <= wb_dat_i[`DPA_FLAGS_HI:`DPA_FLAGS_LO];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            wr_r         <= '0;
            res_r        <= 32'h0;
            done_r       <= 1'b0;
            pc_restore_r <= 1'b0;
            skipped_r    <= 1'b0;
            wrote_r      <= 1'b0;
            count_r      <= '0;
        end else begin
            wr_r.en      <= do_write;
            done_r       <= exec;
            pc_restore_r <= exec && cond_ok && set_f && rd == `DPA_PC_IDX;
            if (exec) begin
                wr_r.idx  <= rd;
                wr_r.data <= res;
                skipped_r <= !cond_ok;
                wrote_r   <= do_write;
            end
            if (exec && cond_ok) begin
                res_r   <= res;
                count_r <= count_r + 1'b1;
            end
        end
    end

    assign wr_o         = wr_r;
    assign flags_o      = flags_r;
    assign done_o       = done_r;
    assign pc_restore_o = pc_restore_r;

    // ****************************************************************
    // wishbone registers
    // ****************************************************************
    assign wb_req     = wb_cyc_i && wb_stb_i;
    // write lands on the edge where the master sees ack
    assign sw_flag_we = wb_req && wb_we_i && ack_r && wb_sel_i[3]
                        && {wb_adr_i[3:2], 2'b00} == `DPA_FLAGS_OFS;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= wb_req && !ack_r;
            dat_r <= 32'h0;
            if (wb_req && !ack_r && !wb_we_i) begin
                unique case ({wb_adr_i[3:2], 2'b00})
                    `DPA_FLAGS_OFS:  dat_r <= {flags_r, 28'h0};
                    `DPA_STATUS_OFS: dat_r <= {29'h0, wrote_r, skipped_r, exec};
                    `DPA_COUNT_OFS:  dat_r <= 32'(count_r);
                    `DPA_RESULT_OFS: dat_r <= res_r;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    cond_skip_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && !cond_ok && !sw_flag_we |=> !wr_o.en && flags_r == $past(flags_r))
        else $error("failed condition still had an effect");
    rn_select_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        issue_valid_i && issue_ready_o |=> rn_idx_o == $past(instr_i[19:16]))
        else $error("first operand index not from instruction");
    imm_rotate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && imm_sel |-> op2 == (({24'h0, spec[7:0]} >> {spec[11:8], 1'b0})
            | ({24'h0, spec[7:0]} << (6'd32 - {1'b0, spec[11:8], 1'b0}))))
        else $error("immediate operand wrongly rotated");
    lsl_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && !imm_sel && spec[11:4] == 8'h00 |-> op2 == rm_val_i && sh_carry == flags_r.c)
        else $error("zero left shift altered value or carry");
    no_set_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && !set_f && !sw_flag_we |=> $stable(flags_r))
        else $error("flags changed without set-flags bit");
    test_no_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && test_op |=> !wr_o.en)
        else $error("test operation wrote destination");
    bit_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && cond_ok && opc == dpa_pkg::DPA_OP_BIT_CLEAR
        |=> wr_o.en && wr_o.data == ($past(op1) & ~$past(op2)))
        else $error("bit clear result wrong");
    add_carry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && cond_ok && opc == dpa_pkg::DPA_OP_ADD_CARRY
        |=> wr_o.data == $past(op1) + $past(op2) + {31'h0, $past(flags_r.c)})
        else $error("add with carry result wrong");
    sub_carry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && cond_ok && opc == dpa_pkg::DPA_OP_SUBTRACT_CARRY
        |=> wr_o.data == $past(op1) - $past(op2) + {31'h0, $past(flags_r.c)} - 32'h1)
        else $error("subtract with carry result wrong");
    move_inv_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && cond_ok && opc == dpa_pkg::DPA_OP_MOVE_INVERTED |=> wr_o.data == ~$past(op2))
        else $error("move inverted result wrong");
    logic_v_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        flag_upd && !is_arith |=> flags_r.v == $past(flags_r.v))
        else $error("logical operation changed overflow");
    nz_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        flag_upd |=> flags_r.n == res_r[31] && flags_r.z == (res_r == 32'h0))
        else $error("negative or zero flag wrong");
    cmp_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        flag_upd && opc == dpa_pkg::DPA_OP_COMPARE
        |=> flags_r.c == ($past(op1) >= $past(op2)) && !wr_o.en)
        else $error("compare carry wrong");
    add_ovf_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        flag_upd && opc == dpa_pkg::DPA_OP_ADD |=> flags_r.v == ($past(op1[31]) == $past(op2[31])
            && res_r[31] != $past(op1[31])))
        else $error("add overflow wrong");
    pc_dest_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && rd == `DPA_PC_IDX && !sw_flag_we |=> $stable(flags_r) ##1 !pc_restore_o)
        else $error("pc destination touched flags");

endmodule // dpa_alu

// file: dpa_regs.svh
`ifndef DPA_REGS_SVH
`define DPA_REGS_SVH

// ****************************************************************
// instruction field positions
// ****************************************************************
`define DPA_COND_HI    31
`define DPA_COND_LO    28
`define DPA_IMM_BIT    25
`define DPA_OPC_HI     24
`define DPA_OPC_LO     21
`define DPA_SET_BIT    20
`define DPA_RN_HI      19
`define DPA_RN_LO      16
`define DPA_RD_HI      15
`define DPA_RD_LO      12
`define DPA_SPEC_HI    11
`define DPA_SPEC_LO    0
`define DPA_RS_HI      11
`define DPA_RS_LO      8
`define DPA_RM_HI      3
`define DPA_RM_LO      0
`define DPA_PC_IDX     4'hf

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define DPA_FLAGS_OFS  4'h0
`define DPA_STATUS_OFS 4'h4
`define DPA_COUNT_OFS  4'h8
`define DPA_RESULT_OFS 4'hc
`define DPA_FLAGS_HI   31
`define DPA_FLAGS_LO   28
`define DPA_FLAGS_RST  4'h0
`define DPA_ST_BUSY    0
`define DPA_ST_SKIP    1
`define DPA_ST_WROTE   2

`endif

// file: dpa_pkg.sv
package dpa_pkg;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } dpa_flags_t;

    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic [31:0] data;
    } dpa_wr_t;

    typedef enum logic [1:0] {
        DPA_ST_IDLE = 2'b01,
        DPA_ST_EXEC = 2'b10
    } dpa_state_t;

    typedef enum logic [3:0] {
        DPA_OP_AND                       = 4'h0,
        DPA_OP_EXCLUSIVE_OR              = 4'h1,
        DPA_OP_SUBTRACT                  = 4'h2,
        DPA_OP_REVERSE_SUBTRACT          = 4'h3,
        DPA_OP_ADD                       = 4'h4,
        DPA_OP_ADD_CARRY                 = 4'h5,
        DPA_OP_SUBTRACT_CARRY            = 4'h6,
        DPA_OP_REVERSE_SUBTRACT_CARRY    = 4'h7,
        DPA_OP_TEST_BITS                 = 4'h8,
        DPA_OP_TEST_EQUIVALENCE          = 4'h9,
        DPA_OP_COMPARE                   = 4'ha,
        DPA_OP_COMPARE_NEGATED           = 4'hb,
        DPA_OP_INCLUSIVE_OR              = 4'hc,
        DPA_OP_MOVE                      = 4'hd,
        DPA_OP_BIT_CLEAR                 = 4'he,
        DPA_OP_MOVE_INVERTED             = 4'hf
    } dpa_opcode_t;

    typedef enum logic [1:0] {
        DPA_SH_LEFT_LOGICAL  = 2'h0,
        DPA_SH_RIGHT_LOGICAL = 2'h1,
        DPA_SH_RIGHT_ARITH   = 2'h2,
        DPA_SH_ROTATE        = 2'h3
    } dpa_shift_t;

endpackage

// file: dpa_shifter.sv
`timescale 1ns/100ps
module dpa_shifter (
    // operand two specifier
    input  wire logic        imm_sel_i,
    input  wire logic [11:0] spec_i,
    // register values and carry in
    input  wire logic [31:0] rm_val_i,
    input  wire logic [31:0] rs_val_i,
    input  wire logic        carry_i,
    // operand two and shifter carry
    output logic      [31:0] op2_o,
    output logic             carry_o
);

    function automatic logic [31:0] ror32(input logic [31:0] v, input logic [4:0] n);
        ror32 = (v >> n) | (v << (6'd32 - {1'b0, n}));
    endfunction

    dpa_pkg::dpa_shift_t sh_type;
    logic [7:0]          amt;
    logic                rrx;
    logic [32:0]         lt;
    logic [32:0]         rt;
    logic signed [32:0]  st;

    always_comb begin
        sh_type = dpa_pkg::dpa_shift_t'(spec_i[6:5]);
        op2_o   = rm_val_i;
        carry_o = carry_i;
        lt      = 33'h0;
        rt      = 33'h0;
        st      = 33'h0;
        // register form: source in low nibble, shift in the upper bits
        amt     = spec_i[4] ? rs_val_i[7:0] : {3'h0, spec_i[11:7]};
        rrx     = !spec_i[4] && spec_i[11:7] == 5'h0 && sh_type == dpa_pkg::DPA_SH_ROTATE;
        if (!spec_i[4] && spec_i[11:7] == 5'h0 && sh_type != dpa_pkg::DPA_SH_LEFT_LOGICAL) begin
            amt = 8'h20;
        end
        if (imm_sel_i) begin
            op2_o = ror32({24'h0, spec_i[7:0]}, {spec_i[11:8], 1'b0});
            if (spec_i[11:8] != 4'h0) begin
                carry_o = op2_o[31];
            end
        end else if (rrx) begin
            op2_o   = {carry_i, rm_val_i[31:1]};
            carry_o = rm_val_i[0];
        end else if (amt != 8'h00) begin
            // amount zero falls through: value passes, old carry kept
            unique case (sh_type)
                dpa_pkg::DPA_SH_LEFT_LOGICAL: begin
                    lt      = {1'b0, rm_val_i} << amt;
                    op2_o   = lt[31:0];
                    carry_o = lt[32];
                end
                dpa_pkg::DPA_SH_RIGHT_LOGICAL: begin
                    rt      = {rm_val_i, 1'b0} >> amt;
                    op2_o   = rt[32:1];
                    carry_o = rt[0];
                end
                dpa_pkg::DPA_SH_RIGHT_ARITH: begin
                    st      = $signed({rm_val_i, 1'b0}) >>> amt;
                    op2_o   = st[32:1];
                    carry_o = st[0];
                end
                dpa_pkg::DPA_SH_ROTATE: begin
                    op2_o   = ror32(rm_val_i, amt[4:0]);
                    carry_o = op2_o[31];
                end
            endcase
        end
    end

endmodule // dpa_shifter

// file: dpa_cond_eval.sv
`timescale 1ns/100ps
module dpa_cond_eval (
    // condition code and flags
    input  wire logic [3:0]          cond_i,
    input  wire dpa_pkg::dpa_flags_t flags_i,
    // verdict
    output logic                     pass_o
);

    always_comb begin
        unique case (cond_i)
            4'h0: pass_o = flags_i.z;
            4'h1: pass_o = !flags_i.z;
            4'h2: pass_o = flags_i.c;
            4'h3: pass_o = !flags_i.c;
            4'h4: pass_o = flags_i.n;
            4'h5: pass_o = !flags_i.n;
            4'h6: pass_o = flags_i.v;
            4'h7: pass_o = !flags_i.v;
            4'h8: pass_o = flags_i.c && !flags_i.z;
            4'h9: pass_o = !flags_i.c || flags_i.z;
            4'ha: pass_o = flags_i.n == flags_i.v;
            4'hb: pass_o = flags_i.n != flags_i.v;
            4'hc: pass_o = !flags_i.z && (flags_i.n == flags_i.v);
            4'hd: pass_o = flags_i.z || (flags_i.n != flags_i.v);
            4'he: pass_o = 1'b1;
            4'hf: pass_o = 1'b0;
        endcase
    end

endmodule // dpa_cond_eval

// file: dpa_rf_model.sv
`timescale 1ns/100ps
module dpa_rf_model (
    // clock
    input  wire logic             ref_clk_i,
    // read ports
    input  wire logic [3:0]       rn_idx_i,
    input  wire logic [3:0]       rm_idx_i,
    input  wire logic [3:0]       rs_idx_i,
    output logic      [31:0]      rn_val_o,
    output logic      [31:0]      rm_val_o,
    output logic      [31:0]      rs_val_o,
    // write port
    input  wire dpa_pkg::dpa_wr_t wr_i
);
    logic [31:0] rf_r [16];
    initial for (int i = 0; i < 16; i++) rf_r[i] = 32'h0;
    // async read, as the core's register file offers
    assign rn_val_o = rf_r[rn_idx_i];
    assign rm_val_o = rf_r[rm_idx_i];
    assign rs_val_o = rf_r[rs_idx_i];
    always @(posedge ref_clk_i) if (wr_i.en === 1'b1) rf_r[wr_i.idx] <= wr_i.data;
endmodule // dpa_rf_model

// file: tb.sv
`timescale 1ns/100ps
module tb;
    logic ref_clk_i = 0, rst_b_i = 0, issue_valid_i = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [31:0] instr_i = 0, wb_dat_i = 0, rn_val_i, rm_val_i, rs_val_i, wb_dat_o;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 0, rn_idx_o, rm_idx_o, rs_idx_o, f;
    logic issue_ready_o, done_o, pc_restore_o, wb_ack_o;
    dpa_pkg::dpa_wr_t wr_o;
    dpa_pkg::dpa_flags_t flags_o;
    int fails = 0, checked = 0, n_exec = 0;
    logic [31:0] lr = 0;
    logic [31:0] m [16];
    always #2 ref_clk_i = ~ref_clk_i;
    dpa_alu DUT (.ref_clk_i, .rst_b_i, .issue_valid_i, .issue_ready_o, .instr_i, .rn_idx_o,
        .rm_idx_o, .rs_idx_o, .rn_val_i, .rm_val_i, .rs_val_i, .wr_o, .flags_o, .done_o,
        .pc_restore_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o);
    dpa_rf_model RF (.ref_clk_i, .rn_idx_i(rn_idx_o), .rm_idx_i(rm_idx_o),
        .rs_idx_i(rs_idx_o), .rn_val_o(rn_val_i), .rm_val_o(rm_val_i),
        .rs_val_o(rs_val_i), .wr_i(wr_o));
    task automatic chk(string nm, logic [36:0] seen, logic [36:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wb(logic we, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk_i);
            if (wb_ack_o === 1'b1) break;
            if (i == 9) begin fails++; print_verdict(); end
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic run(logic [31:0] x);
        logic [63:0] t;
        logic [31:0] a, b, r, p, q;
        logic [32:0] s;
        logic co, ci, ar, pass, w, fu;
        logic [3:0] op;
        int k;
        logic signed [63:0] e;
        logic [31:0] v;
        int sa;
        op = x[24:21];
        a = m[x[19:16]];
        t = {2{24'h0, x[7:0]}} >> {x[11:8], 1'b0};
        v = m[x[3:0]];
        sa = x[4] ? m[x[11:8]][7:0] : x[11:7];
        if (!x[4] && sa == 0 && x[6:5] != 0) sa = 32;
        if (x[6:5] == 3 && sa > 32) sa = (sa - 1) % 32 + 1;
        e = x[6:5] == 2 ? {{32{v[31]}}, v} : (x[6:5] == 3 ? {v, v} : {32'h0, v});
        if (x[25]) begin
            b = t[31:0];
            co = x[11:8] != 0 ? b[31] : f[1];
        end else if (!x[4] && x[11:7] == 0 && x[6:5] == 3) begin
            b = {f[1], v[31:1]};
            co = v[0];
        end else if (sa == 0) begin
            b = v;
            co = f[1];
        end else if (x[6:5] == 0) begin
            e = e << sa;
            b = e[31:0];
            co = e[32];
        end else begin
            e = e >>> (sa - 1);
            b = e[32:1];
            co = e[0];
        end
        ar = op inside {[2:7], 10, 11};
        p = (op == 3 || op == 7) ? b : a;
        q = (op == 3 || op == 7) ? ~a : (op inside {4, 5, 11} ? b : ~b);
        ci = op inside {2, 3, 10} ? 1'b1 : (op inside {5, 6, 7} ? f[1] : 1'b0);
        s = {1'b0, p} + {1'b0, q} + ci;
        case (op)
            0, 8: r = a & b;
            1, 9: r = a ^ b;
            12: r = a | b;
            13: r = b;
            14: r = a & ~b;
            15: r = ~b;
            default: r = s[31:0];
        endcase
        case (x[31:29])
            0: pass = f[2];
            1: pass = f[1];
            2: pass = f[3];
            3: pass = f[0];
            4: pass = f[1] & !f[2];
            5: pass = f[3] == f[0];
            6: pass = !f[2] && f[3] == f[0];
            default: pass = 1'b1;
        endcase
        pass = x[31:29] == 7 ? !x[28] : pass ^ x[28];
        w = pass && !(op inside {[8:11]});
        fu = pass && x[20] && x[15:12] != 4'hf;
        @(posedge ref_clk_i);
        issue_valid_i <= 1'b1;
        instr_i <= x;
        @(posedge ref_clk_i);
        issue_valid_i <= 1'b0;
        for (k = 1; k < 6; k++) begin
            @(posedge ref_clk_i);
            #1;
            if (done_o === 1'b1) break;
        end
        if (k > 5) begin fails++; print_verdict(); end
        chk("latency", k, 1);
        chk("ready", issue_ready_o, 1'b1);
        chk("rn_idx", rn_idx_o, x[19:16]);
        chk("rm_idx", rm_idx_o, x[3:0]);
        chk("rs_idx", rs_idx_o, x[11:8]);
        chk("wr_en", wr_o.en, w);
        if (w) chk("wr", wr_o, {1'b1, x[15:12], r});
        chk("pc_rst", pc_restore_o, pass && x[20] && x[15:12] == 4'hf);
        if (w) m[x[15:12]] = r;
        if (fu) f = {r[31], r == 0, ar ? s[32] : co, ar ? p[31] == q[31] && r[31] != p[31] : f[0]};
        chk("flags", flags_o, f);
        n_exec += pass;
        if (pass) lr = r;
    endtask
    initial begin
        logic [31:0] q;
        void'($urandom(22));
        foreach (m[i]) m[i] = 32'h0;
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        q = $urandom;
        f = q[31:28];
        wb(1'b1, 4'h0, q, q);
        wb(1'b0, 4'h0, 32'h0, q);
        chk("flags_rd", q, {f, 28'h0});
        for (int i = 0; i < 15; i++) begin
            q = $urandom;
            run({12'he3a, 4'h0, i[3:0], q[11:0]});
        end
        repeat (400) begin
            q = $urandom;
            if (!q[25] && q[26]) q[11:4] = 8'h0;
            q[27:26] = 2'b00;
            run(q);
        end
        wb(1'b0, 4'h8, 32'h0, q);
        chk("count", q, n_exec[15:0]);
        wb(1'b0, 4'hc, 32'h0, q);
        chk("result", q, lr);
        print_verdict();
    end
endmodule // tb
